/* File: rtl/sgio_top.sv */
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sgio_consts.svh"
// Summary of operation
// - Pins 8..15 serve host port after reset
// - Pin is general IO only when enabled
// - Direction bit: 0 input, 1 output
// - Sample pull-resistor straps to set boot modes
// - Pins 4..7 also raise external interrupt events
// - Interrupts edge-detected, polarity per bit
module sgio_top (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Shared pins
   input wire logic [`SGIO_PINS-1:0] general_io_pin_i,
   output logic [`SGIO_PINS-1:0] general_io_pin_o,
   output logic [`SGIO_PINS-1:0] general_io_pin_oe_o,
   // Host parallel port data side
   input wire logic [`SGIO_HOST_W-1:0] host_parallel_port_dout_i,
   input wire logic host_parallel_port_doe_i,
   output logic [`SGIO_HOST_W-1:0] host_parallel_port_din_o,
   // Boot straps and interrupt
   output logic [`SGIO_HOST_W-1:0] boot_mode_o,
   output logic irq_o
);
   localparam int HL = `SGIO_HOST_LSB;
   localparam int HW = `SGIO_HOST_W;
   localparam int EL = `SGIO_EXT_LSB;
   localparam int EW = `SGIO_EXT_W;

   sgio_pkg::sgio_state_t s_q; // Registered state
   sgio_pkg::sgio_state_t s_d; // Next state
   sgio_evt_if evt_if ();      // Edge detector link

   // Byte-lane merge, used for every writable register
   function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : wmerge

   // Address decode, used by both read and write paths
   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= `SGIO_OFS_BOOT);
   endfunction : mapped

   // External interrupt lines sit on pins 4..7, pin 7 highest
   assign evt_if.level = s_q.sync2[EL +: EW];
   assign evt_if.pol = s_q.pol;

   // Edge detector
   sgio_edge sgio_edge_inst (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .evt_if(evt_if)
   );

   // All next-state logic
   always_comb begin
      logic [31:0] wv;
      logic [EW-1:0] rd_clr;
      logic do_wr;
      wv = '0;
      rd_clr = '0;
      do_wr = 1'b0;
      s_d = s_q;
      // Two-flop synchroniser on every pin
      s_d.sync1 = general_io_pin_i;
      s_d.sync2 = s_q.sync1;
      s_d.host_din = s_q.sync2[HL +: HW];
      // Straps taken from the second sync stage once it holds them;
      // the raw pin is never read, so a strap edge cannot go metastable
      s_d.boot_fill = {s_q.boot_fill[1:0], 1'b1};
      if (s_q.boot_fill == 3'h3) begin
         s_d.boot = s_q.sync2[HL +: HW];
      end
      // Pin drive: general logic only owns enabled pins
      for (int i = 0; i < `SGIO_PINS; i++) begin
         if (s_q.enable[i]) begin
            s_d.pin_oe[i] = s_q.dir[i];
            s_d.pin_o[i] = s_q.dout[i];
         end else if (i >= HL) begin
            // Host port keeps these while not enabled
            s_d.pin_oe[i] = host_parallel_port_doe_i;
            s_d.pin_o[i] = host_parallel_port_dout_i[i-HL];
         end else begin
            s_d.pin_oe[i] = 1'b0;
            s_d.pin_o[i] = 1'b0;
         end
      end
      // Write channel capture, either order
      if (s_axi_awvalid_i && !s_q.aw_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !s_q.w_got && !s_q.bvalid) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata_i;
         s_d.wstrb = s_axi_wstrb_i;
      end
      do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
      if (do_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = mapped(s_q.awaddr) ? `SGIO_RESP_OKAY : `SGIO_RESP_SLVERR;
         case (s_q.awaddr)
            `SGIO_OFS_ENABLE: begin
               wv = wmerge({16'h0000, s_q.enable}, s_q.wdata, s_q.wstrb);
               s_d.enable = wv[15:0];
            end
            `SGIO_OFS_DIR: begin
               wv = wmerge({16'h0000, s_q.dir}, s_q.wdata, s_q.wstrb);
               s_d.dir = wv[15:0];
            end
            `SGIO_OFS_OUT: begin
               wv = wmerge({16'h0000, s_q.dout}, s_q.wdata, s_q.wstrb);
               s_d.dout = wv[15:0];
            end
            `SGIO_OFS_POL: begin
               wv = wmerge({28'h0000000, s_q.pol}, s_q.wdata, s_q.wstrb);
               s_d.pol = wv[3:0];
            end
            `SGIO_OFS_MASK: begin
               wv = wmerge({28'h0000000, s_q.mask}, s_q.wdata, s_q.wstrb);
               s_d.mask = wv[3:0];
            end
            default: begin
               // Read-only or unmapped: no effect
               wv = '0;
            end
         endcase
      end
      if (s_q.bvalid && s_axi_bready_i) begin
         s_d.bvalid = 1'b0;
      end
      // Read: answer one cycle after address taken
      if (s_axi_arvalid_i && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = mapped(s_axi_araddr_i) ? `SGIO_RESP_OKAY : `SGIO_RESP_SLVERR;
         case (s_axi_araddr_i)
            `SGIO_OFS_ENABLE: s_d.rdata = {16'h0000, s_q.enable};
            `SGIO_OFS_DIR: s_d.rdata = {16'h0000, s_q.dir};
            `SGIO_OFS_OUT: s_d.rdata = {16'h0000, s_q.dout};
            // Input bits only for enabled input pins
            `SGIO_OFS_IN: s_d.rdata = {16'h0000, s_q.sync2 & s_q.enable & ~s_q.dir};
            `SGIO_OFS_POL: s_d.rdata = {28'h0000000, s_q.pol};
            `SGIO_OFS_STATUS: begin
               s_d.rdata = {28'h0000000, s_q.status};
               rd_clr = s_q.status;
            end
            `SGIO_OFS_MASK: s_d.rdata = {28'h0000000, s_q.mask};
            `SGIO_OFS_BOOT: s_d.rdata = {24'h000000, s_q.boot};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      if (s_q.rvalid && s_axi_rready_i) begin
         s_d.rvalid = 1'b0;
      end
      // Ready flags registered so every port comes from a flop
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;
      // Sticky events; a new edge wins over the read clear
      s_d.status = (s_q.status & ~rd_clr) | evt_if.evt;
      s_d.irq = |(s_d.status & s_q.mask);
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.enable <= `SGIO_RST_ENABLE;
         s_q.dir <= `SGIO_RST_DIR;
         s_q.dout <= `SGIO_RST_OUT;
         s_q.pol <= `SGIO_RST_POL;
         s_q.mask <= `SGIO_RST_MASK;
         s_q.bresp <= `SGIO_RESP_OKAY;
         s_q.rresp <= `SGIO_RESP_OKAY;
         s_q.awready <= 1'b1;
         s_q.wready <= 1'b1;
         s_q.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign s_axi_awready_o = s_q.awready;
   assign s_axi_wready_o = s_q.wready;
   assign s_axi_bvalid_o = s_q.bvalid;
   assign s_axi_bresp_o = s_q.bresp;
   assign s_axi_arready_o = s_q.arready;
   assign s_axi_rvalid_o = s_q.rvalid;
   assign s_axi_rdata_o = s_q.rdata;
   assign s_axi_rresp_o = s_q.rresp;
   assign general_io_pin_o = s_q.pin_o;
   assign general_io_pin_oe_o = s_q.pin_oe;
   assign host_parallel_port_din_o = s_q.host_din;
   assign boot_mode_o = s_q.boot;
   assign irq_o = s_q.irq;
endmodule : sgio_top

/* File: rtl/sgio_consts.svh */
`ifndef SGIO_CONSTS_SVH
`define SGIO_CONSTS_SVH
// Register byte offsets
`define SGIO_OFS_ENABLE 8'h00
`define SGIO_OFS_DIR 8'h04
`define SGIO_OFS_OUT 8'h08
`define SGIO_OFS_IN 8'h0c
`define SGIO_OFS_POL 8'h10
`define SGIO_OFS_STATUS 8'h14
`define SGIO_OFS_MASK 8'h18
`define SGIO_OFS_BOOT 8'h1c
// Widths and field positions
`define SGIO_PINS 16
`define SGIO_HOST_LSB 8
`define SGIO_HOST_W 8
`define SGIO_EXT_LSB 4
`define SGIO_EXT_W 4
// Reset values
`define SGIO_RST_ENABLE 16'h0000
`define SGIO_RST_DIR 16'h0000
`define SGIO_RST_OUT 16'h0000
`define SGIO_RST_POL 4'hf
`define SGIO_RST_MASK 4'h0
// Bus answers
`define SGIO_RESP_OKAY 2'b00
`define SGIO_RESP_SLVERR 2'b10
`endif

/* File: rtl/sgio_pkg.sv */
`include "sgio_consts.svh"
package sgio_pkg;
   // Register state of the top module
   typedef struct packed {
      logic [`SGIO_PINS-1:0] enable;  // Per-pin general_io_enable
      logic [`SGIO_PINS-1:0] dir;     // Per-pin gpio_direction
      logic [`SGIO_PINS-1:0] dout;    // Per-pin output data
      logic [`SGIO_PINS-1:0] sync1;   // First sync stage, read by sync2 only
      logic [`SGIO_PINS-1:0] sync2;   // Second sync stage
      logic [`SGIO_PINS-1:0] pin_o;   // Registered pin levels
      logic [`SGIO_PINS-1:0] pin_oe;  // Registered pin enables
      logic [`SGIO_HOST_W-1:0] host_din; // Synced host data to host port
      logic [`SGIO_EXT_W-1:0] pol;    // interrupt_edge_polarity_field
      logic [`SGIO_EXT_W-1:0] status; // Sticky edge events
      logic [`SGIO_EXT_W-1:0] mask;   // Interrupt mask
      logic irq;                      // Interrupt output
      logic [`SGIO_HOST_W-1:0] boot;  // Straps caught after reset
      logic [2:0] boot_fill;          // Ones shift in while the sync chain fills
      logic aw_got;                   // Write address held
      logic w_got;                    // Write data held
      logic awready;                  // Registered write address ready
      logic wready;                   // Registered write data ready
      logic arready;                  // Registered read address ready
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sgio_state_t;

   // Edge detector state
   typedef struct packed {
      logic [`SGIO_EXT_W-1:0] prev; // Level seen last cycle
      logic [2:0] primed;           // Ones shift in until prev holds a real sample
   } sgio_edge_state_t;
endpackage : sgio_pkg

/* File: rtl/sgio_evt_if.sv */
`timescale 1ns/1ps
`include "sgio_consts.svh"
// Carries external interrupt levels in and edge events out
interface sgio_evt_if;
   logic [`SGIO_EXT_W-1:0] level; // Synced pin levels
   logic [`SGIO_EXT_W-1:0] pol;   // 1 = rising, 0 = falling
   logic [`SGIO_EXT_W-1:0] evt;   // One-cycle edge pulses
   modport src (output level, output pol, input evt);
   modport det (input level, input pol, output evt);
endinterface : sgio_evt_if

/* File: rtl/sgio_edge.sv */
`timescale 1ns/1ps
`include "sgio_consts.svh"
module sgio_edge (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   sgio_evt_if.det evt_if
);
   sgio_pkg::sgio_edge_state_t s_q; // Registered state
   sgio_pkg::sgio_edge_state_t s_d; // Next state

   // Edge, not level: compare with last sample per polarity bit
   always_comb begin
      s_d = s_q;
      s_d.prev = evt_if.level;
      s_d.primed = {s_q.primed[1:0], 1'b1};
      evt_if.evt = '0;
      // Sync chain and prev hold reset zeros for three cycles; a pulled-up
      // pin would look like a rising edge, so compare only once they are real
      if (s_q.primed[2]) begin
         evt_if.evt = (evt_if.pol & evt_if.level & ~s_q.prev) |
                      (~evt_if.pol & ~evt_if.level & s_q.prev);
      end
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : sgio_edge

/* File: tb/sgio_checker.sv */
`timescale 1ns/1ps
// Watches the top module's ports for pin roles, straps and read answers
module sgio_checker (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic s_axi_bvalid_o,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [15:0] general_io_pin_i,
   input wire logic [15:0] general_io_pin_o,
   input wire logic [15:0] general_io_pin_oe_o,
   input wire logic [7:0] host_parallel_port_dout_i,
   input wire logic host_parallel_port_doe_i,
   input wire logic [7:0] boot_mode_o
);
   // Set once any write is answered; until then pins keep reset roles
   logic wr_seen_q;
   // Cleared by reset, set by the first write answer
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_seen_q <= 1'b0;
      end else if (s_axi_bvalid_o) begin
         wr_seen_q <= 1'b1;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_HOST_DEFAULT: assert property (!wr_seen_q && $past(rst_n_i) |->
      general_io_pin_oe_o[15:8] == {8{$past(host_parallel_port_doe_i)}} &&
      (!$past(host_parallel_port_doe_i) || general_io_pin_o[15:8] == $past(host_parallel_port_dout_i)))
      else $error("host pins do not follow host port after reset");
   AST_IDLE_PINS: assert property (!wr_seen_q |-> general_io_pin_oe_o[7:0] == 8'h00)
      else $error("disabled pin driven");
   AST_BOOT_CATCH: assert property ($rose(rst_n_i) |-> ##3
      boot_mode_o == $past(general_io_pin_i[15:8], 3)) else $error("straps not caught");
   AST_BOOT_HOLD: assert property ($past(rst_n_i, 4) |-> $stable(boot_mode_o))
      else $error("boot mode changed");
   AST_RD_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   AST_RD_DONE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read answer not released");
   AST_RD_SLVERR: assert property (s_axi_arvalid_i && s_axi_arready_o &&
      s_axi_araddr_i > 8'h1c |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
      else $error("unmapped read not refused");
endmodule : sgio_checker

bind sgio_top sgio_checker sgio_checker_inst (.*);

/* File: tb/sgio_board.sv */
`timescale 1ns/1ps
// Board pads: device drive wins, then the bench's driver, else the pull-up
module sgio_board (
   input wire logic [15:0] pad_val_i,
   input wire logic [15:0] pad_oe_i,
   input wire logic [15:0] drv_en_i,
   input wire logic [15:0] drv_lvl_i,
   output logic [15:0] pad_lvl_o
);
   // Released pads float up, never hold the last driven value
   assign pad_lvl_o = (pad_oe_i & pad_val_i) | (~pad_oe_i & ~drv_en_i)
                      | (~pad_oe_i & drv_en_i & drv_lvl_i);
endmodule : sgio_board

/* File: tb/tb_sgio_top.sv */
`timescale 1ns/1ps
module tb_sgio_top;
   logic core_clk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
   logic s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
   logic s_axi_rvalid_o, s_axi_rready_i, host_parallel_port_doe_i, irq_o;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, host_parallel_port_dout_i;
   logic [7:0] host_parallel_port_din_o, boot_mode_o;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [15:0] general_io_pin_i, general_io_pin_o, general_io_pin_oe_o, drv_en, drv_lvl;
   int mismatches, comparisons;
   sgio_top sgio_top_inst (.*);
   // Pads with pull-ups and a bench-held driver
   sgio_board sgio_board_inst (.pad_val_i(general_io_pin_o), .pad_oe_i(general_io_pin_oe_o),
      .drv_en_i(drv_en), .drv_lvl_i(drv_lvl), .pad_lvl_o(general_io_pin_i));
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : cyc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // A stuck handshake ends the run at once
   task automatic tmo(input int n);
      if (n >= 40) begin
         mismatches++;
         $display("unexpected at %0t: bus timeout", $time);
         finish_test();
      end
   endtask : tmo
   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      do begin
         cyc(1);
         n++;
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o && n < 40);
      tmo(n);
      chk(s_axi_bresp_o, er);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do begin
         cyc(1);
         n++;
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o && n < 40);
      tmo(n);
      chk(s_axi_rdata_o, ed);
      chk(s_axi_rresp_o, er);
   endtask : rd
   // Straps, host default roles, reset values, unmapped places
   task automatic t_reset;
      cyc(4);
      chk(boot_mode_o, 8'ha5);
      drv_en <= 16'h0000;
      host_parallel_port_dout_i <= 8'h3c;
      host_parallel_port_doe_i <= 1'b1;
      cyc(2);
      chk(general_io_pin_oe_o, 16'hff00);
      chk(general_io_pin_o[15:8], 8'h3c);
      rd(8'h1c, 32'ha5, 2'h0);
      rd(8'h00, 32'h0, 2'h0);
      rd(8'h10, 32'hf, 2'h0);
      rd(8'h20, 32'h0, 2'h2);
      wr(8'h24, 32'h1, 2'h2);
      $display("reset test done");
   endtask : t_reset
   // Mixed enables and directions while the host still wants pins 8..15
   task automatic t_gpio;
      wr(8'h00, 32'hff0f, 2'h0);
      wr(8'h04, 32'h0f0f, 2'h0);
      wr(8'h08, 32'h0a05, 2'h0);
      drv_en <= 16'hf0f0;
      drv_lvl <= 16'h9060;
      cyc(4);
      chk(general_io_pin_oe_o, 16'h0f0f);
      chk(general_io_pin_o & general_io_pin_oe_o, 16'h0a05);
      chk(host_parallel_port_din_o, 8'h9a);
      rd(8'h0c, 32'h9000, 2'h0);
      $display("gpio test done");
   endtask : t_gpio
   // Pin 7 edges of both polarities, masking and read-clear
   task automatic t_irq;
      wr(8'h00, 32'hffff, 2'h0);
      wr(8'h18, 32'h8, 2'h0);
      rd(8'h14, 32'h0, 2'h0);
      drv_lvl <= 16'h90e0;
      cyc(6);
      chk(irq_o, 1'b1);
      rd(8'h14, 32'h8, 2'h0);
      cyc(2);
      chk(irq_o, 1'b0);
      wr(8'h10, 32'h7, 2'h0);
      drv_lvl <= 16'h9060;
      cyc(6);
      chk(irq_o, 1'b1);
      wr(8'h18, 32'h0, 2'h0);
      cyc(2);
      chk(irq_o, 1'b0);
      rd(8'h14, 32'h8, 2'h0);
      $display("irq test done");
   endtask : t_irq
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   // Free-running device clock
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end
   // Straps are held on pins 15..8 through reset
   initial begin
      {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i} = 4'h0;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
      {host_parallel_port_dout_i, host_parallel_port_doe_i} = 9'h0;
      {s_axi_bready_i, s_axi_rready_i, s_axi_wstrb_i} = 6'h3f;
      drv_en = 16'hff00;
      drv_lvl = 16'ha500;
      mismatches = 0;
      comparisons = 0;
      cyc(8);
      rst_n_i <= 1'b1;
      t_reset();
      t_gpio();
      t_irq();
      finish_test();
   end
endmodule : tb_sgio_top
